// >>> rtl/gate_spi_defs.svh
// Offsets, field positions, reset values and counts of the gate driver serial port
`ifndef GATE_SPI_DEFS_SVH
`define GATE_SPI_DEFS_SVH

`define ADDR_FAULT_PRIMARY 4'h0
`define ADDR_FAULT_SECONDARY 4'h1
`define ADDR_DRIVER_CONTROL 4'h2
`define ADDR_HIGH_SIDE 4'h3
`define ADDR_LOW_SIDE 4'h4
`define ADDR_OVERCURRENT 4'h5
`define ADDR_CURRENT_SENSE 4'h6
`define ADDR_RESERVED_SLOT 4'h7

`define FRAME_BITS 5'h10
`define ADDR_DONE_COUNT 5'h04
`define DATA_FIRST_COUNT 5'h05
`define DATA_LAST_COUNT 5'h0f
`define BITCOUNT_MAX 5'h11

`define FAULT_ANY_BIT 10
`define DS_OVERCURRENT_BIT 9
`define GATE_FAULT_BIT 8
`define UNDERVOLT_BIT 7
`define THERMAL_BIT 6
`define CLEAR_FAULT_BIT 0
`define LOCK_MSB 10
`define LOCK_LSB 8
`define LOCK_ENGAGE 3'h6
`define LOCK_RELEASE 3'h3
`define DRV_LOCKED_MASK 11'h007

`define RST_STATUS 11'h000
`define RST_DRIVER_CONTROL 11'h000
`define RST_HIGH_SIDE 11'h3ff
`define RST_LOW_SIDE 11'h000
`define RST_OVERCURRENT 11'h000
`define RST_CURRENT_SENSE 11'h000
`define RST_CS_SYNC 3'h7

`endif

// >>> rtl/gate_spi_pkg.sv
// Types shared by the gate driver serial port modules
`default_nettype none
package gate_spi_pkg;
    typedef logic [10:0] reg_word_t;
    typedef reg_word_t [7:0] image_t;

    typedef struct packed {
        logic dir;
        logic [3:0] addr;
        reg_word_t data;
    } spi_word_t;

    typedef struct packed {
        reg_word_t driver_control;
        reg_word_t high_side;
        reg_word_t low_side;
        reg_word_t overcurrent;
        reg_word_t current_sense;
    } control_regs_t;

    typedef struct packed {
        logic [5:0] fet_overcurrent;
        logic [5:0] gate_fault_fet;
        logic supply_undervoltage;
        logic thermal_shutdown;
        logic thermal_warning;
        logic charge_pump_undervoltage;
        logic [2:0] sense_overcurrent;
    } fault_inputs_t;

    typedef struct packed {
        logic [15:0] shift;
        logic [4:0] bit_count;
        reg_word_t tx_data;
    } rx_state_t;

    typedef struct packed {
        logic out_bit;
    } tx_state_t;

    typedef struct packed {
        logic [2:0] cs_sync;
        logic [1:0] sleep_sync;
        fault_inputs_t fault_meta;
        fault_inputs_t fault_sync;
        reg_word_t status_primary;
        reg_word_t status_secondary;
        control_regs_t ctrl;
        image_t read_image;
        logic fault_low;
        logic frame_error;
    } sys_state_t;
endpackage
`default_nettype wire

// >>> rtl/spi_frame_shifter.sv
// Serial clock domain shifter: captures the frame and returns the addressed word
`include "gate_spi_defs.svh"
`default_nettype none
module spi_frame_shifter
    import gate_spi_pkg::*;
(
    input wire logic serial_clock_i,
    input wire logic chip_select_low_i,
    input wire logic serial_in_line_i,
    input wire image_t read_image_i,
    output logic [15:0] frame_word_o,
    output logic [4:0] frame_bits_o,
    output logic serial_out_line_o,
    output logic serial_out_oe_n_o
);
    logic fresh;
    logic [3:0] addr_now;
    logic [4:0] out_index;
    rx_state_t rx_reg;
    rx_state_t rx_next;
    tx_state_t tx_reg;
    tx_state_t tx_next;

    // Set while deselected, so the first falling edge of a frame restarts the shifter
    always_ff @(negedge serial_clock_i or posedge chip_select_low_i)
    begin
        if (chip_select_low_i)
            fresh <= 1'b1; // see RULE17
        else
            fresh <= 1'b0;
    end

    always_comb
    begin
        rx_next = rx_reg;
        addr_now = {rx_reg.shift[2:0], serial_in_line_i};
        if (fresh)
        begin
            rx_next.shift = {15'h0000, serial_in_line_i}; // see RULE15
            rx_next.bit_count = 5'h01;
        end
        else
        begin
            rx_next.shift = {rx_reg.shift[14:0], serial_in_line_i}; // see RULE15
            if (rx_reg.bit_count != `BITCOUNT_MAX)
                rx_next.bit_count = rx_reg.bit_count + 5'h01; // see RULE16
        end
        // Image is frozen by the core domain while selected, so this read is stable
        if (!fresh && rx_reg.bit_count == `ADDR_DONE_COUNT)
            rx_next.tx_data = addr_now[3] ? 11'h000 : read_image_i[addr_now[2:0]]; // see RULE3 RULE4
        // Stray edges while deselected must not disturb the finished frame
        if (chip_select_low_i)
            rx_next = rx_reg; // see RULE17
    end

    always_ff @(negedge serial_clock_i)
    begin
        rx_reg <= rx_next;
    end

    always_comb
    begin
        tx_next.out_bit = 1'b0; // see RULE5
        out_index = `DATA_LAST_COUNT - rx_reg.bit_count;
        if (!fresh && rx_reg.bit_count >= `DATA_FIRST_COUNT && rx_reg.bit_count <= `DATA_LAST_COUNT)
            tx_next.out_bit = rx_reg.tx_data[out_index[3:0]]; // see RULE5 RULE15
    end

    always_ff @(posedge serial_clock_i)
    begin
        tx_reg <= tx_next;
    end

    assign frame_word_o = rx_reg.shift;
    assign frame_bits_o = rx_reg.bit_count;
    assign serial_out_line_o = tx_reg.out_bit & ~chip_select_low_i;
    assign serial_out_oe_n_o = chip_select_low_i; // see RULE17
endmodule
`default_nettype wire

// >>> rtl/gate_driver_spi_register_port.sv
// Serial register port of a three-phase gate driver
//
// Overview of operation
// RULE1 - Power-up, sleep entry and supply undervoltage return registers to defaults.
// RULE2 - Frame is 16 bits: direction, 4-bit address, 11 data bits.
// RULE3 - Write frame returns the old register value, then stores new data.
// RULE4 - Read frame returns the register value and changes nothing.
// RULE5 - Returned word: five meaningless bits, then eleven data bits, MSB first.
// RULE6 - Reserved bit positions hold zero after reset.
// RULE7 - Master must not write reserved or unlisted registers or bits.
// RULE8 - Master should engage the lock after configuring.
// RULE9 - Both status registers are read-only and clear at reset.
// RULE10 - Status bit 10 ORs reported faults and mirrors the fault pin.
// RULE11 - Status bit 9 flags any drain-source overcurrent.
// RULE12 - Status bit 8 flags any gate drive fault.
// RULE13 - Status bit 7 flags supply undervoltage, bit 6 thermal shutdown.
// RULE14 - Status bits 5..0 flag overcurrent per transistor, A high first.
// RULE15 - Input sampled on falling edge, output changed on rising, MSB first.
// RULE16 - Only exactly 16 clocks make a valid frame; others are discarded. A select pulse with no clock reuses the previous frame and its count.
// RULE17 - While deselected, clock and input are ignored and output floats.
// RULE18 - Master keeps clock low at select edges and 400 ns gaps.
// RULE19 - Discarded or aborted frames leave all registers untouched.
`include "gate_spi_defs.svh"
`default_nettype none
module gate_driver_spi_register_port
    import gate_spi_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic serial_clock_i,
    input wire logic chip_select_low_i,
    input wire logic serial_in_line_i,
    input wire logic sleep_mode_i,
    input wire fault_inputs_t fault_inputs_i,
    output logic serial_out_line_o,
    output logic serial_out_oe_n_o,
    output control_regs_t control_o,
    output logic fault_output_low_o,
    output logic frame_error_o
);
    sys_state_t state_reg;
    sys_state_t state_next;
    logic [15:0] frame_word;
    logic [4:0] frame_bits;
    spi_word_t word;
    logic frame_end;
    logic frame_ok;
    logic do_write;
    logic locked;
    logic hold_defaults;
    logic clear_faults;
    reg_word_t primary_now;
    reg_word_t secondary_now;
    fault_inputs_t f;

    spi_frame_shifter shifter
    (
        .serial_clock_i(serial_clock_i),
        .chip_select_low_i(chip_select_low_i),
        .serial_in_line_i(serial_in_line_i),
        .read_image_i(state_reg.read_image),
        .frame_word_o(frame_word),
        .frame_bits_o(frame_bits),
        .serial_out_line_o(serial_out_line_o),
        .serial_out_oe_n_o(serial_out_oe_n_o)
    );

    always_comb
    begin
        state_next = state_reg;
        f = state_reg.fault_sync;
        word = spi_word_t'(frame_word); // see RULE2
        // Shifter words are quiet once select is high, so sampling after the sync is safe
        frame_end = state_reg.cs_sync[1] & ~state_reg.cs_sync[2];
        frame_ok = frame_end && (frame_bits == `FRAME_BITS); // see RULE16
        do_write = frame_ok && !word.dir; // see RULE3 RULE19
        locked = state_reg.ctrl.high_side[`LOCK_MSB:`LOCK_LSB] == `LOCK_ENGAGE;
        hold_defaults = state_reg.sleep_sync[1] | f.supply_undervoltage;
        clear_faults = state_reg.ctrl.driver_control[`CLEAR_FAULT_BIT];

        state_next.cs_sync = {state_reg.cs_sync[1:0], chip_select_low_i};
        state_next.sleep_sync = {state_reg.sleep_sync[0], sleep_mode_i};
        state_next.fault_meta = fault_inputs_i;
        state_next.fault_sync = state_reg.fault_meta;
        state_next.frame_error = frame_end && !frame_ok; // see RULE16

        // Sticky fault bits; a new event beats a clear in the same cycle
        primary_now = clear_faults ? `RST_STATUS : state_reg.status_primary;
        secondary_now = clear_faults ? `RST_STATUS : state_reg.status_secondary;
        primary_now[5:0] = primary_now[5:0] | f.fet_overcurrent; // see RULE14
        primary_now[`THERMAL_BIT] = primary_now[`THERMAL_BIT] | f.thermal_shutdown; // see RULE13
        primary_now[`UNDERVOLT_BIT] = primary_now[`UNDERVOLT_BIT] | f.supply_undervoltage; // see RULE13
        primary_now[`GATE_FAULT_BIT] = primary_now[`GATE_FAULT_BIT] | (|f.gate_fault_fet); // see RULE12
        primary_now[`DS_OVERCURRENT_BIT] = primary_now[`DS_OVERCURRENT_BIT] | (|f.fet_overcurrent); // see RULE11
        primary_now[`FAULT_ANY_BIT] = |primary_now[`DS_OVERCURRENT_BIT:`THERMAL_BIT]; // see RULE10
        secondary_now = secondary_now | {f.sense_overcurrent, f.thermal_warning,
                                         f.charge_pump_undervoltage, f.gate_fault_fet};
        state_next.status_primary = primary_now;
        state_next.status_secondary = secondary_now;
        state_next.fault_low = ~primary_now[`FAULT_ANY_BIT]; // see RULE10

        // Clear-fault request lasts one cycle
        state_next.ctrl.driver_control[`CLEAR_FAULT_BIT] = 1'b0;

        if (do_write)
        begin
            unique case (word.addr)
                `ADDR_DRIVER_CONTROL:
                begin
                    if (locked)
                        state_next.ctrl.driver_control = (state_reg.ctrl.driver_control & ~`DRV_LOCKED_MASK)
                                                       | (word.data & `DRV_LOCKED_MASK);
                    else
                        state_next.ctrl.driver_control = word.data; // see RULE3
                end
                `ADDR_HIGH_SIDE:
                begin
                    if (locked)
                    begin
                        if (word.data[`LOCK_MSB:`LOCK_LSB] == `LOCK_RELEASE)
                            state_next.ctrl.high_side[`LOCK_MSB:`LOCK_LSB] = `LOCK_RELEASE;
                    end
                    else
                    begin
                        state_next.ctrl.high_side[7:0] = word.data[7:0];
                        if (word.data[`LOCK_MSB:`LOCK_LSB] == `LOCK_ENGAGE)
                            state_next.ctrl.high_side[`LOCK_MSB:`LOCK_LSB] = `LOCK_ENGAGE;
                    end
                end
                `ADDR_LOW_SIDE:
                begin
                    if (!locked)
                        state_next.ctrl.low_side = word.data;
                end
                `ADDR_OVERCURRENT:
                begin
                    if (!locked)
                        state_next.ctrl.overcurrent = word.data;
                end
                `ADDR_CURRENT_SENSE:
                begin
                    if (!locked)
                        state_next.ctrl.current_sense = word.data;
                end
                // Status, reserved and unlisted addresses ignore writes
                // Left empty so the self-clearing bit is not restored here
                default: // see RULE9 RULE6
                begin
                end
            endcase
        end

        if (hold_defaults)
        begin
            state_next.ctrl.driver_control = `RST_DRIVER_CONTROL; // see RULE1
            state_next.ctrl.high_side = `RST_HIGH_SIDE;
            state_next.ctrl.low_side = `RST_LOW_SIDE;
            state_next.ctrl.overcurrent = `RST_OVERCURRENT;
            state_next.ctrl.current_sense = `RST_CURRENT_SENSE;
        end
        if (state_reg.sleep_sync[1])
        begin
            state_next.status_primary = `RST_STATUS; // see RULE1
            state_next.status_secondary = `RST_STATUS;
            state_next.fault_low = 1'b1;
        end

        // Image follows the registers only while deselected, frozen during a frame
        if (state_reg.cs_sync[1])
        begin
            state_next.read_image[`ADDR_FAULT_PRIMARY] = state_reg.status_primary;
            state_next.read_image[`ADDR_FAULT_SECONDARY] = state_reg.status_secondary;
            state_next.read_image[`ADDR_DRIVER_CONTROL] = state_reg.ctrl.driver_control;
            state_next.read_image[`ADDR_HIGH_SIDE] = state_reg.ctrl.high_side;
            state_next.read_image[`ADDR_LOW_SIDE] = state_reg.ctrl.low_side;
            state_next.read_image[`ADDR_OVERCURRENT] = state_reg.ctrl.overcurrent;
            state_next.read_image[`ADDR_CURRENT_SENSE] = state_reg.ctrl.current_sense;
            state_next.read_image[`ADDR_RESERVED_SLOT] = `RST_STATUS; // see RULE6
        end

        if (reset_i)
        begin
            state_next.cs_sync = `RST_CS_SYNC;
            state_next.sleep_sync = 2'h0;
            state_next.fault_meta = '0;
            state_next.fault_sync = '0;
            state_next.status_primary = `RST_STATUS; // see RULE9
            state_next.status_secondary = `RST_STATUS;
            state_next.ctrl.driver_control = `RST_DRIVER_CONTROL; // see RULE1
            state_next.ctrl.high_side = `RST_HIGH_SIDE;
            state_next.ctrl.low_side = `RST_LOW_SIDE;
            state_next.ctrl.overcurrent = `RST_OVERCURRENT;
            state_next.ctrl.current_sense = `RST_CURRENT_SENSE;
            state_next.read_image = '0;
            state_next.fault_low = 1'b1;
            state_next.frame_error = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        state_reg <= state_next;
    end

    assign control_o = state_reg.ctrl;
    assign fault_output_low_o = state_reg.fault_low;
    assign frame_error_o = state_reg.frame_error;
endmodule
`default_nettype wire

// >>> verification/gate_driver_spi_register_port_asserts.sv
// Pin-level checks of the gate driver serial register port
`include "gate_spi_defs.svh"
`default_nettype none
module gate_driver_spi_register_port_asserts
    import gate_spi_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic chip_select_low_i,
    input wire logic sleep_mode_i,
    input wire fault_inputs_t fault_inputs_i,
    input wire logic serial_out_line_o,
    input wire logic serial_out_oe_n_o,
    input wire control_regs_t control_o,
    input wire logic fault_output_low_o,
    input wire logic frame_error_o
);
    localparam control_regs_t ctrl_defaults = {`RST_DRIVER_CONTROL, `RST_HIGH_SIDE, `RST_LOW_SIDE,
        `RST_OVERCURRENT, `RST_CURRENT_SENSE};
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // Five cycles covers the two-stage synchroniser plus the register
    sequence s_asleep;
        sleep_mode_i [*5];
    endsequence
    sequence s_undervolt;
        fault_inputs_i.supply_undervoltage [*5];
    endsequence
    sequence s_in_frame;
        (!chip_select_low_i && !sleep_mode_i && !fault_inputs_i.supply_undervoltage) [*6];
    endsequence
    a_reset_defaults: assert property (disable iff (1'b0) reset_i |=> control_o == ctrl_defaults && fault_output_low_o)
        else $error("defaults not restored by reset");
    a_sleep_defaults: assert property (s_asleep |-> control_o == ctrl_defaults)
        else $error("defaults not restored in sleep");
    a_undervolt_defaults: assert property (s_undervolt |-> control_o == ctrl_defaults)
        else $error("defaults not restored on undervoltage");
    a_enable_follows_select: assert property (serial_out_oe_n_o == chip_select_low_i)
        else $error("output enable differs from select");
    a_idle_output_low: assert property (chip_select_low_i && $past(chip_select_low_i) |-> !serial_out_line_o)
        else $error("output moves while deselected");
    a_error_one_cycle: assert property (frame_error_o |=> !frame_error_o)
        else $error("frame error longer than one cycle");
    a_error_no_update: assert property (frame_error_o |-> $stable(control_o) [*3])
        else $error("bad frame changed control");
    a_frame_no_update: assert property (s_in_frame |-> $stable(control_o))
        else $error("control changed inside a frame");
    a_fault_pin_low: assert property (fault_inputs_i.fet_overcurrent != 6'h00 |-> ##[1:6] !fault_output_low_o)
        else $error("overcurrent not shown on fault pin");
endmodule

bind gate_driver_spi_register_port gate_driver_spi_register_port_asserts u_gate_driver_spi_register_port_asserts (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .chip_select_low_i(chip_select_low_i),
    .sleep_mode_i(sleep_mode_i),
    .fault_inputs_i(fault_inputs_i),
    .serial_out_line_o(serial_out_line_o),
    .serial_out_oe_n_o(serial_out_oe_n_o),
    .control_o(control_o),
    .fault_output_low_o(fault_output_low_o),
    .frame_error_o(frame_error_o)
);
`default_nettype wire

// >>> verification/spi_master_model.sv
// Serial master model driving frames into the register port
`default_nettype none
module spi_master_model
(
    output logic serial_clock_o,
    output logic chip_select_low_o,
    output logic serial_in_line_o,
    input wire logic serial_out_line_i
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        serial_clock_o = 1'b0;
        chip_select_low_o = 1'b0;
        serial_in_line_o = 1'b0;
        // Rise after time zero so the shifter sees a real select edge
        #1 chip_select_low_o = 1'b1;
    end
    // Clock runs only inside a frame, 12 ns period
    task automatic transfer(input logic [15:0] word, input int bits, output logic [15:0] rx);
        rx = 16'h0000;
        // Offset keeps select edges clear of the core clock edges
        #3;
        serial_in_line_o = word[15];
        chip_select_low_o = 1'b0;
        #50;
        for (int i = 0; i < bits; i++)
        begin
            #6 serial_clock_o = 1'b1;
            // Data moves on the rising edge so the falling-edge sample never races
            serial_in_line_o = (i < 16) ? word[15 - i] : 1'b0;
            #6 rx = {rx[14:0], serial_out_line_i};
            serial_clock_o = 1'b0;
        end
        #6 chip_select_low_o = 1'b1;
        serial_in_line_o = ~serial_in_line_o;
        // A full frame takes 670 ns, so later frames keep the same offset
        #419;
    endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench of the gate driver serial register port
`include "gate_spi_defs.svh"
`default_nettype none
module tb
    import gate_spi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, reset_i, sleep_mode_i, serial_clock, select_low, serial_in, serial_out, out_oe_n, fault_low, frame_error;
    fault_inputs_t fault_inputs;
    control_regs_t control;
    logic [15:0] rx;
    int mismatches = 0;
    int checks = 0;
    int frame_errors = 0;

    gate_driver_spi_register_port u_gate_driver_spi_register_port (.clk_i(clk_i), .reset_i(reset_i),
        .serial_clock_i(serial_clock), .chip_select_low_i(select_low), .serial_in_line_i(serial_in),
        .sleep_mode_i(sleep_mode_i), .fault_inputs_i(fault_inputs), .serial_out_line_o(serial_out),
        .serial_out_oe_n_o(out_oe_n), .control_o(control), .fault_output_low_o(fault_low), .frame_error_o(frame_error));
    spi_master_model u_spi_master_model (.serial_clock_o(serial_clock), .chip_select_low_o(select_low),
        .serial_in_line_o(serial_in), .serial_out_line_i(serial_out));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
        if (frame_error === 1'b1)
            frame_errors++;

    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        checks++;
        if (seen !== expected)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic access(input logic dir, input logic [3:0] addr, input reg_word_t data, input reg_word_t expected);
        u_spi_master_model.transfer({dir, addr, data}, 16, rx);
        check(rx, {5'h00, expected});
    endtask
    // Faults are sticky, so each case ends with a clear command
    task automatic fault_case(input fault_inputs_t f, input reg_word_t expected);
        @(posedge clk_i);
        fault_inputs <= f;
        repeat (8) @(posedge clk_i);
        check({15'h0000, fault_low}, {15'h0000, ~expected[10]});
        access(1'b1, `ADDR_FAULT_PRIMARY, 11'h000, expected);
        @(posedge clk_i);
        fault_inputs <= '0;
        repeat (4) @(posedge clk_i);
        access(1'b0, `ADDR_DRIVER_CONTROL, 11'h001, 11'h000);
        access(1'b1, `ADDR_FAULT_PRIMARY, 11'h000, 11'h000);
    endtask
    task automatic finish_test;
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #300000;
        mismatches++;
        finish_test();
    end
    initial
    begin
        reset_i = 1'b1;
        sleep_mode_i = 1'b0;
        fault_inputs = '0;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        // Address 8 is outside the map and reads back zero
        for (int a = 0; a < 9; a++)
            access(1'b1, 4'(a), 11'h000, (a == 3) ? `RST_HIGH_SIDE : 11'h000);
        access(1'b0, `ADDR_LOW_SIDE, 11'h555, 11'h000);
        access(1'b1, `ADDR_LOW_SIDE, 11'h7ff, 11'h555);
        access(1'b1, `ADDR_LOW_SIDE, 11'h000, 11'h555);
        check(16'(control.low_side), 16'h0555);
        access(1'b0, `ADDR_FAULT_PRIMARY, 11'h7ff, 11'h000);
        access(1'b1, `ADDR_FAULT_PRIMARY, 11'h000, 11'h000);
        u_spi_master_model.transfer({1'b0, `ADDR_LOW_SIDE, 11'h0aa}, 15, rx);
        u_spi_master_model.transfer({1'b0, `ADDR_LOW_SIDE, 11'h0aa}, 17, rx);
        check(16'(frame_errors), 16'h0002);
        access(1'b1, `ADDR_LOW_SIDE, 11'h000, 11'h555);
        for (int i = 0; i < 6; i++)
            fault_case(19'h0_2000 << i, 11'h600 | (11'h001 << i));
        fault_case(19'h0_1000, 11'h500);
        fault_case(19'h0_0020, 11'h440);
        fault_case(19'h0_0040, 11'h480);
        access(1'b1, `ADDR_LOW_SIDE, 11'h000, 11'h000);
        access(1'b0, `ADDR_OVERCURRENT, 11'h123, 11'h000);
        @(posedge clk_i);
        sleep_mode_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        sleep_mode_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        access(1'b1, `ADDR_OVERCURRENT, 11'h000, 11'h000);
        // Lock, try a blocked write, then unlock
        access(1'b0, `ADDR_HIGH_SIDE, 11'h6ab, `RST_HIGH_SIDE);
        access(1'b0, `ADDR_LOW_SIDE, 11'h111, 11'h000);
        access(1'b0, `ADDR_HIGH_SIDE, 11'h355, 11'h6ab);
        access(1'b1, `ADDR_LOW_SIDE, 11'h000, 11'h000);
        check(16'(control.high_side), 16'h03ab);
        finish_test();
    end
endmodule
`default_nettype wire
